// file: sac_pkg.sv
// Shared constants and types of the serial converter control block
package sac_pkg;

	// Serial exchange shape
	localparam int         XCHG_BITS       = 8;
	localparam int         ADDR_BITS       = 4;
	localparam int         CHANNELS        = 11;
	localparam logic [3:0] ADDR_LAST_CNT   = 4'h3;
	localparam logic [3:0] XCHG_LAST_CNT   = 4'h7;
	localparam logic [3:0] BIT_CNT_RESET   = 4'h0;

	// Address decode
	localparam logic [3:0] ADDR_HALF_SCALE = 4'hb;
	localparam logic [1:0] ADDR_TEST_TOP   = 2'h3;

	// Values after reset and at conversion start
	localparam logic [7:0] RESULT_RESET    = 8'h00;
	localparam logic [7:0] SAR_START       = 8'h80;

	// Conversion length in conversion-clock cycles
	localparam int         CONV_MIN        = 48;
	localparam int         CONV_MAX        = 64;
	localparam logic [6:0] CONV_MIN_CNT    = 7'(CONV_MIN);
	localparam logic [4:0] CONV_SPREAD     = 5'(CONV_MAX - CONV_MIN);
	localparam logic [6:0] SAR_STEPS       = 7'(XCHG_BITS);

	// Sampling continues this long after the last falling shift edge
	localparam int         SYS_CLK_HZ      = 50_000_000;
	localparam int         SAMPLE_NS       = 1000;
	localparam int         SAMPLE_CYCLES   = (SAMPLE_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [5:0] SAMPLE_LAST     = 6'(SAMPLE_CYCLES - 1);
	localparam logic [5:0] SAMPLE_RESET    = 6'h00;

	// Exchange sequencer states
	typedef enum logic [1:0] {
		XS_READY,
		XS_SETTLE,
		XS_BUSY
	} sac_xstate_e;

	// Multiplexer selection carried to the analog side
	typedef struct packed {
		logic [CHANNELS-1:0] chan_sel;
		logic                half_scale;
		logic                test_mode;
	} sac_mux_s;

	localparam sac_mux_s MUX_RESET = '{chan_sel: 11'h001, half_scale: 1'b0, test_mode: 1'b0};

endpackage

// file: sac_sync.sv
// Two-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
`default_nettype none

module sac_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] nxt_meta;
	logic [W-1:0] nxt_q;

	// Refused at elaboration
	if (W < 1) begin : g_bad_width
		$error("sac_sync: width must be at least one");
	end

	always_comb begin
		nxt_meta = i_d;
		nxt_q    = meta_ff;
	end

	always_ff @(posedge i_clk) begin
		meta_ff <= nxt_meta;
		o_q     <= nxt_q;
	end

endmodule
`default_nettype wire

// file: sac_conv.sv
// Conversion-clock side: select qualification and the approximation sequence
`timescale 1ns/1ps
`default_nettype none

module sac_conv (
	input  wire logic       i_clk_conv,
	input  wire logic       i_rst,
	input  wire logic       i_cs_n,
	input  wire logic       i_start_tgl,
	input  wire logic       i_cmp_keep,
	output logic            o_abort_tgl,
	output logic            o_done_tgl,
	output logic      [7:0] o_result,
	output logic      [7:0] o_approximation_register
);

	logic [2:0] sync_q;
	logic       rst_c;
	logic       start_s;
	logic       cs_s;

	logic       cs_prev_ff, cs_filt_ff, start_prev_ff, busy_ff;
	logic       nxt_cs_filt, nxt_busy, nxt_abort, nxt_done;
	logic [6:0] cnt_ff, len_ff, nxt_cnt, nxt_len;
	logic [4:0] rnd_ff, nxt_rnd;
	logic [7:0] nxt_sar, nxt_result;
	logic [2:0] idx;

	// Select, start request and reset all enter this domain through two flops
	sac_sync #(.W(3)) u_sync (
		.i_clk (i_clk_conv),
		.i_d   ({i_rst, i_start_tgl, i_cs_n}),
		.o_q   (sync_q)
	);

	assign rst_c   = sync_q[2];
	assign start_s = sync_q[1];
	assign cs_s    = sync_q[0];
	assign idx     = 3'(3'h7 - cnt_ff[2:0]);

	always_comb begin
		nxt_cs_filt = cs_filt_ff;
		nxt_busy    = busy_ff;
		nxt_cnt     = cnt_ff;
		nxt_len     = len_ff;
		nxt_sar     = o_approximation_register;
		nxt_result  = o_result;
		nxt_abort   = o_abort_tgl;
		nxt_done    = o_done_tgl;
		// Free-running spread makes the length unpredictable
		nxt_rnd     = (rnd_ff == sac_pkg::CONV_SPREAD) ? 5'h00 : 5'(rnd_ff + 5'h01);
		// Level accepted only after two equal samples; shorter spikes are lost
		if (cs_s == cs_prev_ff) begin
			nxt_cs_filt = cs_s;
		end
		if (cs_filt_ff && !nxt_cs_filt) begin
			// Recognised strobe kills any conversion
			nxt_busy  = 1'b0;
			nxt_abort = ~o_abort_tgl;
		end else if (start_s != start_prev_ff) begin
			nxt_busy = 1'b1;
			nxt_cnt  = 7'h00;
			nxt_len  = 7'(sac_pkg::CONV_MIN_CNT + {2'b00, rnd_ff});
			nxt_sar  = sac_pkg::SAR_START;
		end else if (busy_ff) begin
			nxt_cnt = 7'(cnt_ff + 7'h01);
			if (cnt_ff < sac_pkg::SAR_STEPS) begin
				if (!i_cmp_keep) begin
					nxt_sar[idx] = 1'b0;
				end
				if (idx != 3'h0) begin
					nxt_sar[3'(idx - 3'h1)] = 1'b1;
				end
			end
			if (cnt_ff == 7'(len_ff - 7'h01)) begin
				nxt_busy   = 1'b0;
				nxt_result = o_approximation_register;
				nxt_done   = ~o_done_tgl;
			end
		end
	end

	always_ff @(posedge i_clk_conv) begin
		if (rst_c) begin
			cs_prev_ff               <= 1'b1;
			cs_filt_ff               <= 1'b1;
			start_prev_ff            <= 1'b0;
			busy_ff                  <= 1'b0;
			cnt_ff                   <= 7'h00;
			len_ff                   <= sac_pkg::CONV_MIN_CNT;
			rnd_ff                   <= 5'h00;
			o_approximation_register <= sac_pkg::RESULT_RESET;
			o_result                 <= sac_pkg::RESULT_RESET;
			o_abort_tgl              <= 1'b0;
			o_done_tgl               <= 1'b0;
		end else begin
			cs_prev_ff               <= cs_s;
			cs_filt_ff               <= nxt_cs_filt;
			start_prev_ff            <= start_s;
			busy_ff                  <= nxt_busy;
			cnt_ff                   <= nxt_cnt;
			len_ff                   <= nxt_len;
			rnd_ff                   <= nxt_rnd;
			o_approximation_register <= nxt_sar;
			o_result                 <= nxt_result;
			o_abort_tgl              <= nxt_abort;
			o_done_tgl               <= nxt_done;
		end
	end

endmodule
`default_nettype wire

// file: sac_top.sv
// Serial I/O and conversion sequencing of an 8-bit serial converter
`timescale 1ns/1ps
`default_nettype none

module sac_top (
	input  wire logic                         i_clk_sys,
	input  wire logic                         i_rst,
	input  wire logic                         i_clk_conv,
	input  wire logic                         i_cs_n,
	input  wire logic                         i_sclk,
	input  wire logic                         i_serial_address_in,
	input  wire logic                         i_cmp_keep,
	output logic                              o_sdo,
	output logic                              o_sdo_oe,
	output logic      [sac_pkg::CHANNELS-1:0] o_chan_sel,
	output logic                              o_half_scale_test_voltage_sel,
	output logic                              o_test_mode,
	output logic                              o_sample,
	output logic                              o_result_valid,
	output logic      [7:0]                   o_approximation_register
);

	// Synchronised pins and crossing toggles
	logic [2:0] pin_s;
	logic [1:0] tgl_s;
	logic       cs_s;
	logic       sclk_s;
	logic       di_s;
	logic       abort_s;
	logic       done_s;

	// Edge history
	logic sclk_prev_ff;
	logic abort_prev_ff;
	logic done_prev_ff;
	logic nxt_sclk_prev;
	logic nxt_abort_prev;
	logic nxt_done_prev;
	logic sclk_rise;
	logic sclk_fall;
	logic abort_evt;
	logic done_evt;

	// Exchange sequencer state
	sac_pkg::sac_xstate_e state_ff;
	sac_pkg::sac_xstate_e nxt_state;
	logic [7:0]           sreg_ff;
	logic [7:0]           nxt_sreg;
	logic                 di_hold_ff;
	logic                 nxt_di_hold;
	logic [3:0]           bit_cnt_ff;
	logic [3:0]           nxt_bit_cnt;
	logic [5:0]           settle_ff;
	logic [5:0]           nxt_settle;
	logic                 start_tgl_ff;
	logic                 nxt_start_tgl;
	logic                 sample_ff;
	logic                 nxt_sample;
	logic                 oe_ff;
	logic                 nxt_oe;
	logic                 valid_ff;
	logic                 nxt_valid;
	sac_pkg::sac_mux_s    mux_ff;
	sac_pkg::sac_mux_s    nxt_mux;

	// Address decode
	logic [3:0]                   addr_word;
	logic [sac_pkg::CHANNELS-1:0] chan_hit;
	logic                         addr_take;

	// From the conversion-clock side
	logic       abort_tgl;
	logic       done_tgl;
	logic [7:0] conv_result;

	// Pins cross into this clock before any logic reads them
	sac_sync #(.W(3)) u_pin_sync (
		.i_clk (i_clk_sys),
		.i_d   ({i_cs_n, i_sclk, i_serial_address_in}),
		.o_q   (pin_s)
	);

	// Event toggles from the conversion clock
	sac_sync #(.W(2)) u_tgl_sync (
		.i_clk (i_clk_sys),
		.i_d   ({abort_tgl, done_tgl}),
		.o_q   (tgl_s)
	);

	sac_conv u_conv (
		.i_clk_conv               (i_clk_conv),
		.i_rst                    (i_rst),
		.i_cs_n                   (i_cs_n),
		.i_start_tgl              (start_tgl_ff),
		.i_cmp_keep               (i_cmp_keep),
		.o_abort_tgl              (abort_tgl),
		.o_done_tgl               (done_tgl),
		.o_result                 (conv_result),
		.o_approximation_register (o_approximation_register)
	);

	assign cs_s    = pin_s[2];
	assign sclk_s  = pin_s[1];
	assign di_s    = pin_s[0];
	assign abort_s = tgl_s[1];
	assign done_s  = tgl_s[0];

	assign sclk_rise = sclk_s && !sclk_prev_ff;
	assign sclk_fall = !sclk_s && sclk_prev_ff;
	assign abort_evt = abort_s != abort_prev_ff;
	assign done_evt  = done_s != done_prev_ff;

	// Address as it stands once the fourth bit has been taken, first bit on top
	assign addr_word = {sreg_ff[2:0], di_hold_ff};

	// Fourth accepted falling edge: address complete
	assign addr_take = (state_ff == sac_pkg::XS_READY) && !cs_s && sclk_fall && !abort_evt
		&& (bit_cnt_ff == sac_pkg::ADDR_LAST_CNT);

	// One comparator per analog channel
	genvar gi;
	generate
		for (gi = 0; gi < sac_pkg::CHANNELS; gi++) begin : g_chan
			assign chan_hit[gi] = (addr_word == 4'(gi)) && (addr_word[3:2] != sac_pkg::ADDR_TEST_TOP);
		end
	endgenerate

	// Counters must be able to hold the package's figures
	if (sac_pkg::SAMPLE_CYCLES < 1 || sac_pkg::SAMPLE_CYCLES > 64) begin : g_bad_sample
		$error("sac_top: sampling window does not fit its counter");
	end
	if (sac_pkg::CHANNELS > 11) begin : g_bad_channels
		$error("sac_top: more channels than address codes");
	end

	// Outputs straight from flops
	assign o_sdo                         = sreg_ff[7];
	assign o_sdo_oe                      = oe_ff;
	assign o_chan_sel                    = mux_ff.chan_sel;
	assign o_half_scale_test_voltage_sel = mux_ff.half_scale;
	assign o_test_mode                   = mux_ff.test_mode;
	assign o_sample                      = sample_ff;
	assign o_result_valid                = valid_ff;

	always_comb begin
		nxt_state     = state_ff;
		nxt_sreg      = sreg_ff;
		nxt_di_hold   = di_hold_ff;
		nxt_bit_cnt   = bit_cnt_ff;
		nxt_settle    = settle_ff;
		nxt_start_tgl = start_tgl_ff;
		nxt_sample    = sample_ff;
		nxt_valid     = valid_ff;
		if (abort_evt) begin
			// Restart the exchange; the stale word is marked untrusted
			nxt_state   = sac_pkg::XS_READY;
			nxt_bit_cnt = sac_pkg::BIT_CNT_RESET;
			nxt_sreg    = conv_result;
			nxt_sample  = 1'b0;
			nxt_valid   = 1'b0;
		end else begin
			unique case (state_ff)
				sac_pkg::XS_READY: begin
					// Shift clock honoured only with select low
					if (!cs_s) begin
						if (sclk_rise) begin
							nxt_di_hold = di_s;
						end
						if (sclk_fall) begin
							// Shared register: next lower bit out, address bit
							nxt_sreg    = {sreg_ff[6:0], di_hold_ff};
							nxt_bit_cnt = 4'(bit_cnt_ff + 4'h1);
							if (bit_cnt_ff == sac_pkg::ADDR_LAST_CNT) begin
								// Address complete; start sampling
								nxt_sample = 1'b1;
							end
							if (bit_cnt_ff == sac_pkg::XCHG_LAST_CNT) begin
								// Eighth falling edge ends the exchange
								nxt_state  = sac_pkg::XS_SETTLE;
								nxt_settle = sac_pkg::SAMPLE_RESET;
							end
						end
					end
				end
				sac_pkg::XS_SETTLE: begin
					nxt_settle = 6'(settle_ff + 6'h01);
					if (settle_ff == sac_pkg::SAMPLE_LAST) begin
						// Sampling window over; hold and start converting
						nxt_sample    = 1'b0;
						nxt_start_tgl = !start_tgl_ff;
						// Clearing the shared register drives the output low
						nxt_sreg      = sac_pkg::RESULT_RESET;
						nxt_state     = sac_pkg::XS_BUSY;
					end
				end
				sac_pkg::XS_BUSY: begin
					// Shift clock ignored until the result lands
					if (done_evt) begin
						// New MSB appears at once if select is low
						nxt_sreg    = conv_result;
						nxt_valid   = 1'b1;
						nxt_bit_cnt = sac_pkg::BIT_CNT_RESET;
						nxt_state   = sac_pkg::XS_READY;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state_ff      <= sac_pkg::XS_READY;
			sreg_ff       <= sac_pkg::RESULT_RESET;
			di_hold_ff    <= 1'b0;
			bit_cnt_ff    <= sac_pkg::BIT_CNT_RESET;
			settle_ff     <= sac_pkg::SAMPLE_RESET;
			start_tgl_ff  <= 1'b0;
			sample_ff     <= 1'b0;
			valid_ff      <= 1'b0;
		end else begin
			state_ff      <= nxt_state;
			sreg_ff       <= nxt_sreg;
			di_hold_ff    <= nxt_di_hold;
			bit_cnt_ff    <= nxt_bit_cnt;
			settle_ff     <= nxt_settle;
			start_tgl_ff  <= nxt_start_tgl;
			sample_ff     <= nxt_sample;
			valid_ff      <= nxt_valid;
		end
	end

	// Edge history; reset levels match the idle pins and toggles
	always_comb begin
		nxt_sclk_prev  = sclk_s;
		nxt_abort_prev = abort_s;
		nxt_done_prev  = done_s;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			sclk_prev_ff  <= 1'b0;
			abort_prev_ff <= 1'b0;
			done_prev_ff  <= 1'b0;
		end else begin
			sclk_prev_ff  <= nxt_sclk_prev;
			abort_prev_ff <= nxt_abort_prev;
			done_prev_ff  <= nxt_done_prev;
		end
	end

	// Output driven only while select is low
	always_comb begin
		nxt_oe = !cs_s;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			oe_ff <= 1'b0;
		end else begin
			oe_ff <= nxt_oe;
		end
	end

	// Multiplexer selection taken once the fourth address bit is
	always_comb begin
		nxt_mux = mux_ff;
		if (addr_take) begin
			nxt_mux.chan_sel   = chan_hit;
			nxt_mux.half_scale = addr_word == sac_pkg::ADDR_HALF_SCALE;
			nxt_mux.test_mode  = addr_word[3:2] == sac_pkg::ADDR_TEST_TOP;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			mux_ff <= sac_pkg::MUX_RESET;
		end else begin
			mux_ff <= nxt_mux;
		end
	end

endmodule
`default_nettype wire

// file: sac_top_properties.sv
// Port assertions of the serial converter control block
`timescale 1ns/1ps
`default_nettype none

module sac_checker (
	input wire logic        i_clk_sys,
	input wire logic        i_rst,
	input wire logic        i_cs_n,
	input wire logic        o_sdo,
	input wire logic        o_sdo_oe,
	input wire logic [10:0] o_chan_sel,
	input wire logic        o_half_scale_test_voltage_sel,
	input wire logic        o_test_mode,
	input wire logic        o_sample,
	input wire logic        o_result_valid
);
	logic [2:0] up_ff;
	logic [2:0] nxt_up;
	logic [4:0] low_ff;
	logic [4:0] nxt_low;

	// Cycles since reset and cycles of select held low, both saturating
	always_comb begin
		nxt_up = (up_ff == 3'h7) ? up_ff : up_ff + 3'h1;
		nxt_low = (low_ff == 5'h1f) ? low_ff : low_ff + 5'h01;
		if (i_cs_n) begin
			nxt_low = 5'h00;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		up_ff <= i_rst ? 3'h0 : nxt_up;
		low_ff <= i_rst ? 5'h00 : nxt_low;
	end

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);

	sequence s_cs_low; !i_cs_n [*4] ##0 up_ff == 3'h7; endsequence
	sequence s_conv_start; $fell(o_sample) ##0 low_ff == 5'h1f; endsequence
	property p_oe_on; s_cs_low |-> o_sdo_oe; endproperty
	property p_oe_off; i_cs_n [*4] |-> !o_sdo_oe; endproperty
	property p_mux_excl; !(o_half_scale_test_voltage_sel && o_test_mode); endproperty
	property p_chan_onehot; !o_half_scale_test_voltage_sel && !o_test_mode |-> $onehot(o_chan_sel); endproperty
	property p_mux_at_sample;
		$changed({o_chan_sel, o_half_scale_test_voltage_sel, o_test_mode}) |-> $rose(o_sample);
	endproperty
	property p_sample_hold; $rose(o_sample) ##0 low_ff == 5'h1f |=> o_sample [*8]; endproperty
	property p_sdo_clear; s_conv_start |-> !o_sdo [*8]; endproperty
	property p_valid_abort; $fell(o_result_valid) |-> low_ff != 5'h1f; endproperty

	a_oe_on: assert property (p_oe_on) else $error("output not enabled");
	a_oe_off: assert property (p_oe_off) else $error("output enabled while idle");
	a_mux_excl: assert property (p_mux_excl) else $error("test voltage and test mode together");
	a_chan_onehot: assert property (p_chan_onehot) else $error("channel select not one-hot");
	a_mux_at_sample: assert property (p_mux_at_sample) else $error("mux changed off sampling start");
	a_sample_hold: assert property (p_sample_hold) else $error("sampling cut short");
	a_sdo_clear: assert property (p_sdo_clear) else $error("output not low in conversion");
	a_valid_abort: assert property (p_valid_abort) else $error("result dropped without strobe");
endmodule

bind sac_top sac_checker i_sac_checker (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cs_n(i_cs_n), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
	.o_chan_sel(o_chan_sel), .o_half_scale_test_voltage_sel(o_half_scale_test_voltage_sel),
	.o_test_mode(o_test_mode), .o_sample(o_sample), .o_result_valid(o_result_valid)
);
`default_nettype wire

// file: sac_host.sv
// Behavioural host driving select, shift clock and serial address
`timescale 1ns/1ps
`default_nettype none

module sac_host (
	input  wire logic i_clk_sys,
	input  wire logic i_sdo,
	output logic      o_cs_n,
	output logic      o_sclk,
	output logic      o_addr
);
	localparam int HALF = 8;

	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_addr = 1'b0;
	end

	task automatic ticks(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask

	task automatic select(input logic lvl);
		o_cs_n = lvl;
		ticks(16);
	endtask

	task automatic xfer(input logic [3:0] a, input int n, output logic [7:0] res);
		logic [7:0] word;
		word = {a, ~a};
		res = 8'h00;
		if (o_cs_n) select(1'b0);
		for (int i = 0; i < n; i++) begin
			o_addr = word[7 - i];
			ticks(HALF);
			o_sclk = 1'b1;
			ticks(HALF);
			res = {res[6:0], i_sdo};
			o_sclk = 1'b0;
			if (i < n - 1) ticks(HALF);
		end
		// Released line shows the inverse of its last value
		o_addr = ~o_addr;
	endtask

	task automatic stray(input int n);
		repeat (n) begin
			o_sclk = 1'b1;
			ticks(HALF);
			o_sclk = 1'b0;
			ticks(HALF);
		end
	endtask

	task automatic glitch();
		o_cs_n = ~o_cs_n;
		ticks(1);
		o_cs_n = ~o_cs_n;
		ticks(HALF);
	endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Testbench of the serial converter control block
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic        clk_sys;
	logic        clk_conv;
	logic        rst;
	logic        cs_n;
	logic        sclk;
	logic        addr_in;
	logic        cmp_keep;
	logic        sdo;
	logic        sdo_oe;
	logic [10:0] chan_sel;
	logic        half_sel;
	logic        test_mode;
	logic        sample;
	logic        valid;
	logic [7:0]  approximation_register;
	logic [7:0]  target;
	logic [7:0]  last;
	int          miscompares;
	int          checks_done;

	always #10 clk_sys = ~clk_sys;
	always #15 clk_conv = ~clk_conv;
	// Comparator stand-in: keep the trial bit while the code is not above the input
	always @(posedge clk_conv) #1 cmp_keep = (approximation_register <= target);

	sac_top i_sac_top (
		.i_clk_sys(clk_sys), .i_rst(rst), .i_clk_conv(clk_conv), .i_cs_n(cs_n), .i_sclk(sclk),
		.i_serial_address_in(addr_in), .i_cmp_keep(cmp_keep), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
		.o_chan_sel(chan_sel), .o_half_scale_test_voltage_sel(half_sel), .o_test_mode(test_mode),
		.o_sample(sample), .o_result_valid(valid), .o_approximation_register(approximation_register)
	);
	sac_host i_sac_host (
		.i_clk_sys(clk_sys), .i_sdo(sdo), .o_cs_n(cs_n), .o_sclk(sclk), .o_addr(addr_in)
	);

	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask

	task automatic check(input logic [10:0] got, input logic [10:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic strobe();
		i_sac_host.select(1'b1);
		i_sac_host.select(1'b0);
	endtask

	// Settle after the last fall, then conversion until the new top bit shows
	task automatic wait_conv(input logic [3:0] a);
		int n;
		n = 0;
		while (sample === 1'b1 && n < 80) begin
			tick();
			n++;
			if (n == 6) check(11'(sdo), 11'(a[3]));
		end
		check(11'(n >= 50 && n <= 58), 11'h001);
		n = 0;
		while (sdo !== 1'b1 && n < 150) begin
			tick();
			n++;
		end
		check(11'(n >= 72 && n <= 112), 11'h001);
		repeat (20) tick();
	endtask

	task automatic t_reset();
		check(chan_sel, 11'h001);
		check(11'({sdo_oe, half_sel, test_mode, sample, valid}), 11'h000);
		$display("Test reset values done");
	endtask

	task automatic t_codes();
		logic [7:0] res;
		for (int a = 0; a < 16; a++) begin
			target = 8'h80 | 8'(a * 7);
			i_sac_host.xfer(4'(a), 8, res);
			check(11'(res), 11'(last));
			last = target;
			if (a < 11) check(chan_sel, 11'h001 << a);
			check(11'({half_sel, test_mode}), 11'({a == 11, a >= 12}));
			wait_conv(4'(a));
			check(11'(valid), 11'h001);
		end
		$display("Test address codes done");
	endtask

	task automatic t_cs_high();
		logic [7:0] res;
		target = 8'hc3;
		i_sac_host.xfer(4'h2, 8, res);
		last = target;
		// Let the eighth fall land before select rises
		repeat (4) tick();
		i_sac_host.select(1'b1);
		check(11'(sdo_oe), 11'h000);
		i_sac_host.stray(4);
		repeat (150) tick();
		check(11'(valid), 11'h001);
		i_sac_host.glitch();
		repeat (12) tick();
		check(11'(valid), 11'h001);
		target = 8'h9a;
		i_sac_host.xfer(4'h3, 8, res);
		check(11'(res), 11'(last));
		last = target;
		wait_conv(4'h3);
		$display("Test select high done");
	endtask

	task automatic t_abort();
		logic [7:0] res;
		i_sac_host.xfer(4'h1, 3, res);
		strobe();
		check(11'({valid, sample}), 11'h000);
		target = 8'hb4;
		i_sac_host.xfer(4'h6, 8, res);
		repeat (20) tick();
		strobe();
		check(11'({valid, sample}), 11'h000);
		i_sac_host.xfer(4'h6, 8, res);
		wait_conv(4'h6);
		check(11'(valid), 11'h001);
		$display("Test abort done");
	endtask

	initial begin
		repeat (40000) @(posedge clk_sys);
		miscompares++;
		complete_run();
	end

	initial begin
		clk_sys = 1'b0;
		clk_conv = 1'b0;
		rst = 1'b1;
		cmp_keep = 1'b0;
		target = 8'h00;
		last = sac_pkg::RESULT_RESET;
		miscompares = 0;
		checks_done = 0;
		repeat (20) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		repeat (10) tick();
		t_reset();
		t_codes();
		t_cs_high();
		t_abort();
		complete_run();
	end
endmodule
`default_nettype wire
